/* hdl/mcr_pkg.sv */
// package for the misc control register bank at 0x16..0x1f
// assumes byte-wide registers reached over a plain strobe port
package mcr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] MCR_ADDR_ANALOG_PIN = 8'h16;
  localparam logic [7:0] MCR_ADDR_OFFSET_ADJ = 8'h17;
  localparam logic [7:0] MCR_ADDR_EDGE_SEL = 8'h18;
  localparam logic [7:0] MCR_ADDR_TMR1_HIGH = 8'h19;
  localparam logic [7:0] MCR_ADDR_ANA_EN = 8'h1A;
  localparam logic [7:0] MCR_ADDR_RFC_CTRL = 8'h1B;
  localparam logic [7:0] MCR_ADDR_TMR4_HIGH = 8'h1C;
  localparam logic [7:0] MCR_ADDR_TRIM_HIGH = 8'h1D;
  localparam logic [7:0] MCR_ADDR_TRIM_LOW = 8'h1E;
  localparam logic [7:0] MCR_ADDR_INT2_REG = 8'h1F;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] MCR_RST_ANALOG_PIN = 8'h00;
  localparam logic [5:0] MCR_RST_OFFSET_ADJ = 6'h00;
  localparam logic [7:0] MCR_RST_EDGE_SEL = 8'h05;
  localparam logic [1:0] MCR_RST_2BIT = 2'h0;
  localparam logic [3:0] MCR_RST_NIBBLE = 4'h0;
  localparam logic MCR_RST_BIT = 1'b0;
  // ****************************************
  // field positions
  // ****************************************
  localparam int MCR_BIT_EDGE2 = 7;
  localparam int MCR_BIT_SEL2 = 6;
  localparam int MCR_BIT_SEL1 = 5;
  localparam int MCR_BIT_SEL0 = 4;
  localparam int MCR_BIT_TOP = 7;
  localparam int MCR_BIT_T4F = 6;
  localparam int MCR_BIT_INT2E = 3;
  localparam int MCR_BIT_T4E = 2;
  // edge codes and rfc pad code bounds
  localparam logic [1:0] MCR_EDGE_RISE = 2'h1;
  localparam logic [1:0] MCR_EDGE_FALL = 2'h2;
  localparam logic [1:0] MCR_EDGE_BOTH = 2'h3;
  localparam logic [3:0] MCR_PAD_LAST = 4'hD;
  localparam logic [3:0] MCR_PAD_PB_BASE = 4'h8;
  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [2:0] portb_analog_only;
    logic [4:0] porta_analog_only;
  } mcr_analog_t;
  typedef struct packed {
    logic offset_direction;
    logic [4:0] offset_magnitude;
  } mcr_offset_t;
  typedef struct packed {
    logic ext_irq2_edge;
    logic ext_irq2_pin_select;
    logic ext_irq1_pin_select;
    logic ext_irq0_pin_select;
    logic [1:0] ext_irq1_edge;
    logic [1:0] ext_irq0_edge;
  } mcr_edge_t;
  typedef struct packed {
    logic [1:0] pwm_ch4_duty_upper;
    logic [1:0] pwm_ch3_duty_upper;
    logic [1:0] pwm_ch2_duty_upper;
    logic [1:0] pwm_ch1_duty_upper;
  } mcr_duty_t;
  typedef struct packed {
    logic rise;
    logic fall;
  } mcr_trig_t;
endpackage

/* hdl/mcr_top.sv */
// misc control register bank, offsets 0x16..0x1f
// assumes a core-side strobe bus, read data one cycle after the strobe
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module mcr_top #(
  parameter logic [7:0] FACTORY_TRIM = 8'h80 // arbitrary default trim
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic slow_mode_in,
  input wire logic [1:0] timer1_count_hi_in,
  input wire logic [1:0] timer4_count_hi_in,
  input wire logic timer4_underflow_in,
  input wire logic ext_irq2_pin_in,
  input wire logic ext_irq1_pin_in,
  input wire logic ext_irq0_pin_in,
  output mcr_pkg::mcr_analog_t analog_out,
  output mcr_pkg::mcr_offset_t offset_out,
  output mcr_pkg::mcr_edge_t edge_out,
  output mcr_pkg::mcr_duty_t duty_out,
  output logic [1:0] timer1_reload_hi_out,
  output logic [1:0] timer4_reload_hi_out,
  output logic comparator_on_out,
  output logic res_freq_on_out,
  output logic [3:0] res_freq_pad_out,
  output logic [7:0] porta_rfc_pad_out,
  output logic [5:0] portb_rfc_pad_out,
  output logic [10:0] rc_trim_value_out,
  output logic ext_irq2_flag_out,
  output logic timer_four_underflow_flag_out,
  output logic ext_irq2_enable_out,
  output logic timer_four_underflow_enable_out,
  output logic ext_irq2_req_out,
  output logic timer_four_underflow_req_out,
  output logic ext_irq1_event_out,
  output logic ext_irq0_event_out
);
  // ****************************************
  // write decode
  // ****************************************
  logic wr_analog, wr_offset, wr_edge, wr_t1, wr_ana, wr_rfc, wr_t4, wr_th, wr_tl, wr_int2;
  assign wr_analog = wr_in && (addr_in == mcr_pkg::MCR_ADDR_ANALOG_PIN);
  assign wr_offset = wr_in && (addr_in == mcr_pkg::MCR_ADDR_OFFSET_ADJ);
  assign wr_edge = wr_in && (addr_in == mcr_pkg::MCR_ADDR_EDGE_SEL);
  assign wr_t1 = wr_in && (addr_in == mcr_pkg::MCR_ADDR_TMR1_HIGH);
  assign wr_ana = wr_in && (addr_in == mcr_pkg::MCR_ADDR_ANA_EN);
  assign wr_rfc = wr_in && (addr_in == mcr_pkg::MCR_ADDR_RFC_CTRL);
  assign wr_t4 = wr_in && (addr_in == mcr_pkg::MCR_ADDR_TMR4_HIGH);
  assign wr_th = wr_in && (addr_in == mcr_pkg::MCR_ADDR_TRIM_HIGH);
  assign wr_tl = wr_in && (addr_in == mcr_pkg::MCR_ADDR_TRIM_LOW);
  assign wr_int2 = wr_in && (addr_in == mcr_pkg::MCR_ADDR_INT2_REG);

  // ****************************************
  // analog pin and offset registers
  // ****************************************
  // pin selects go straight to the pad ring as analog-only controls
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      analog_out <= mcr_pkg::MCR_RST_ANALOG_PIN;
    end else if (wr_analog) begin
      analog_out <= wdata_in;
    end
  end

  // magnitude and sign are handed to the converter as is
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      offset_out <= mcr_pkg::MCR_RST_OFFSET_ADJ;
    end else if (wr_offset) begin
      offset_out <= wdata_in[5:0];
    end
  end

  // ****************************************
  // interrupt pin and edge select
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      edge_out <= mcr_pkg::MCR_RST_EDGE_SEL;
    end else if (wr_edge) begin
      edge_out <= wdata_in;
    end
  end

  // edge detection of the three external pins, gated by pin select
  logic [2:0] pin_d_r;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pin_d_r <= 3'h0;
    end else begin
      pin_d_r <= {ext_irq2_pin_in, ext_irq1_pin_in, ext_irq0_pin_in};
    end
  end

  mcr_pkg::mcr_trig_t t2, t1, t0;
  assign t2 = '{rise: ext_irq2_pin_in & ~pin_d_r[2], fall: ~ext_irq2_pin_in & pin_d_r[2]};
  assign t1 = '{rise: ext_irq1_pin_in & ~pin_d_r[1], fall: ~ext_irq1_pin_in & pin_d_r[1]};
  assign t0 = '{rise: ext_irq0_pin_in & ~pin_d_r[0], fall: ~ext_irq0_pin_in & pin_d_r[0]};

  // two-bit edge code to a hit; reserved code never fires
  function automatic logic edge_hit(input logic [1:0] code, input mcr_pkg::mcr_trig_t t);
    logic hit;
    hit = 1'b0;
    case (code)
      mcr_pkg::MCR_EDGE_RISE: hit = t.rise;
      mcr_pkg::MCR_EDGE_FALL: hit = t.fall;
      mcr_pkg::MCR_EDGE_BOTH: hit = t.rise | t.fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic irq2_hit, irq1_hit, irq0_hit;
  assign irq2_hit = edge_out.ext_irq2_pin_select &&
    (edge_out.ext_irq2_edge ? t2.rise : t2.fall);
  assign irq1_hit = edge_out.ext_irq1_pin_select && edge_hit(edge_out.ext_irq1_edge, t1);
  assign irq0_hit = edge_out.ext_irq0_pin_select && edge_hit(edge_out.ext_irq0_edge, t0);

  // irq1 pulse for the main flag register, which lives outside this bank
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_irq1_event_out <= 1'b0;
    end else begin
      ext_irq1_event_out <= irq1_hit;
    end
  end

  // irq0 pulse, same one-cycle form so the far flag sets exactly once
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_irq0_event_out <= 1'b0;
    end else begin
      ext_irq0_event_out <= irq0_hit;
    end
  end

  // ****************************************
  // timer and pwm high bits
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer1_reload_hi_out <= mcr_pkg::MCR_RST_2BIT;
      duty_out.pwm_ch2_duty_upper <= mcr_pkg::MCR_RST_2BIT;
      duty_out.pwm_ch1_duty_upper <= mcr_pkg::MCR_RST_2BIT;
    end else if (wr_t1) begin
      timer1_reload_hi_out <= wdata_in[5:4];
      duty_out.pwm_ch2_duty_upper <= wdata_in[3:2];
      duty_out.pwm_ch1_duty_upper <= wdata_in[1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer4_reload_hi_out <= mcr_pkg::MCR_RST_2BIT;
      duty_out.pwm_ch4_duty_upper <= mcr_pkg::MCR_RST_2BIT;
      duty_out.pwm_ch3_duty_upper <= mcr_pkg::MCR_RST_2BIT;
    end else if (wr_t4) begin
      timer4_reload_hi_out <= wdata_in[7:6];
      duty_out.pwm_ch4_duty_upper <= wdata_in[3:2];
      duty_out.pwm_ch3_duty_upper <= wdata_in[1:0];
    end
  end

  // ****************************************
  // comparator and rfc control
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      comparator_on_out <= mcr_pkg::MCR_RST_BIT;
    end else if (wr_ana) begin
      comparator_on_out <= wdata_in[mcr_pkg::MCR_BIT_TOP];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      res_freq_on_out <= mcr_pkg::MCR_RST_BIT;
      res_freq_pad_out <= mcr_pkg::MCR_RST_NIBBLE;
    end else if (wr_rfc) begin
      res_freq_on_out <= wdata_in[mcr_pkg::MCR_BIT_TOP];
      res_freq_pad_out <= wdata_in[3:0];
    end
  end

  // pad one-hot decode, registered; follows the select a cycle later
  logic [7:0] pa_pad_nxt;
  logic [5:0] pb_pad_nxt;
  logic [3:0] pb_index;
  assign pb_index = res_freq_pad_out - mcr_pkg::MCR_PAD_PB_BASE;
  always_comb begin
    pa_pad_nxt = 8'h00;
    pb_pad_nxt = 6'h00;
    if (res_freq_on_out) begin
      if (!res_freq_pad_out[3]) begin
        pa_pad_nxt[res_freq_pad_out[2:0]] = 1'b1;
      end else if (res_freq_pad_out <= mcr_pkg::MCR_PAD_LAST) begin
        pb_pad_nxt[pb_index[2:0]] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      porta_rfc_pad_out <= 8'h00;
      portb_rfc_pad_out <= 6'h00;
    end else begin
      porta_rfc_pad_out <= pa_pad_nxt;
      portb_rfc_pad_out <= pb_pad_nxt;
    end
  end

  // ****************************************
  // rc oscillator trim
  // ****************************************
  // writes outside slow mode are dropped so the running clock never jumps
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rc_trim_value_out <= {FACTORY_TRIM, 3'h0};
    end else if (slow_mode_in) begin
      if (wr_th) begin
        rc_trim_value_out[10:8] <= wdata_in[2:0];
      end
      if (wr_tl) begin
        rc_trim_value_out[7:0] <= wdata_in;
      end
    end
  end

  // ****************************************
  // second interrupt register
  // ****************************************
  // a new event wins over a software clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_irq2_flag_out <= mcr_pkg::MCR_RST_BIT;
    end else if (irq2_hit) begin
      ext_irq2_flag_out <= 1'b1;
    end else if (wr_int2) begin
      ext_irq2_flag_out <= wdata_in[mcr_pkg::MCR_BIT_TOP];
    end
  end

  // same priority here, so an underflow is never lost to a racing clear
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer_four_underflow_flag_out <= mcr_pkg::MCR_RST_BIT;
    end else if (timer4_underflow_in) begin
      timer_four_underflow_flag_out <= 1'b1;
    end else if (wr_int2) begin
      timer_four_underflow_flag_out <= wdata_in[mcr_pkg::MCR_BIT_T4F];
    end
  end

  // irq2 enable, off after reset so no request leaks before software asks
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_irq2_enable_out <= mcr_pkg::MCR_RST_BIT;
    end else if (wr_int2) begin
      ext_irq2_enable_out <= wdata_in[mcr_pkg::MCR_BIT_INT2E];
    end
  end

  // underflow enable, same reset state as the irq2 enable
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer_four_underflow_enable_out <= mcr_pkg::MCR_RST_BIT;
    end else if (wr_int2) begin
      timer_four_underflow_enable_out <= wdata_in[mcr_pkg::MCR_BIT_T4E];
    end
  end

  // irq2 request level follows flag and enable, one cycle behind
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      ext_irq2_req_out <= 1'b0;
    end else begin
      ext_irq2_req_out <= ext_irq2_flag_out & ext_irq2_enable_out;
    end
  end

  // underflow request, same lag; registered so the output has no glitch
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      timer_four_underflow_req_out <= 1'b0;
    end else begin
      timer_four_underflow_req_out <= timer_four_underflow_flag_out & timer_four_underflow_enable_out;
    end
  end

  // ****************************************
  // read back
  // ****************************************
  // unmapped addresses and unused bits read zero
  logic [7:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 8'h00;
    case (addr_in)
      mcr_pkg::MCR_ADDR_ANALOG_PIN: rdata_nxt = analog_out;
      mcr_pkg::MCR_ADDR_OFFSET_ADJ: rdata_nxt = {2'h0, offset_out};
      mcr_pkg::MCR_ADDR_EDGE_SEL: rdata_nxt = edge_out;
      mcr_pkg::MCR_ADDR_TMR1_HIGH: rdata_nxt = {2'h0, timer1_count_hi_in, duty_out[3:0]};
      mcr_pkg::MCR_ADDR_ANA_EN: rdata_nxt = {comparator_on_out, 7'h00};
      mcr_pkg::MCR_ADDR_RFC_CTRL: rdata_nxt = {res_freq_on_out, 3'h0, res_freq_pad_out};
      mcr_pkg::MCR_ADDR_TMR4_HIGH: rdata_nxt = {timer4_count_hi_in, 2'h0, duty_out[7:4]};
      mcr_pkg::MCR_ADDR_TRIM_HIGH: rdata_nxt = {5'h00, rc_trim_value_out[10:8]};
      mcr_pkg::MCR_ADDR_TRIM_LOW: rdata_nxt = rc_trim_value_out[7:0];
      mcr_pkg::MCR_ADDR_INT2_REG: rdata_nxt = {ext_irq2_flag_out, timer_four_underflow_flag_out, 2'h0,
        ext_irq2_enable_out, timer_four_underflow_enable_out, 2'h0};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_nxt;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule

/* test/mcr_properties.sv */
// concurrent checks for the misc control register bank
// assumes binding to mcr_top; sees only the top module's ports
`timescale 1ns/10ps
module mcr_properties (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic slow_mode_in,
  input wire logic timer4_underflow_in,
  input wire logic ext_irq2_pin_in,
  input wire logic ext_irq1_pin_in,
  input wire mcr_pkg::mcr_edge_t edge_out,
  input wire logic [1:0] timer1_reload_hi_out,
  input wire logic comparator_on_out,
  input wire logic res_freq_on_out,
  input wire logic [7:0] porta_rfc_pad_out,
  input wire logic [5:0] portb_rfc_pad_out,
  input wire logic [10:0] rc_trim_value_out,
  input wire logic ext_irq2_flag_out,
  input wire logic timer_four_underflow_flag_out,
  input wire logic ext_irq2_enable_out,
  input wire logic ext_irq2_req_out,
  input wire logic ext_irq1_event_out
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ****************************************
  // edge detection steps
  // ****************************************
  sequence irq1_rise_s;
    edge_out.ext_irq1_pin_select && edge_out.ext_irq1_edge == 2'h1 && $rose(ext_irq1_pin_in);
  endsequence
  sequence irq2_rise_s;
    edge_out.ext_irq2_pin_select && edge_out.ext_irq2_edge && $rose(ext_irq2_pin_in);
  endsequence
  // ****************************************
  // port relations
  // ****************************************
  read_idle_zero_a:
    assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  comparator_write_a:
    assert property (wr_in && addr_in == 8'h1A |=> comparator_on_out == $past(wdata_in[7]))
    else $error("comparator enable does not follow write");
  reload_write_a:
    assert property (wr_in && addr_in == 8'h19 |=> timer1_reload_hi_out == $past(wdata_in[5:4]))
    else $error("timer one reload bits do not follow write");
  trim_locked_a:
    assert property (!slow_mode_in |=> $stable(rc_trim_value_out))
    else $error("trim changed outside slow mode");
  underflow_set_a:
    assert property (timer4_underflow_in |=> timer_four_underflow_flag_out)
    else $error("underflow flag not set");
  flag_sticky_a:
    assert property (ext_irq2_flag_out && !(wr_in && addr_in == 8'h1F) |=> ext_irq2_flag_out)
    else $error("irq2 flag dropped without a write");
  irq2_flag_set_a:
    assert property (irq2_rise_s |-> ##[1:3] ext_irq2_flag_out)
    else $error("irq2 flag missed a selected edge");
  irq1_event_a:
    assert property (irq1_rise_s |-> ##[1:3] ext_irq1_event_out)
    else $error("irq1 event missed a rising edge");
  request_pair_a:
    assert property (ext_irq2_req_out == $past(ext_irq2_flag_out && ext_irq2_enable_out))
    else $error("irq2 request not flag and enable");
  pad_gated_a:
    assert property (!res_freq_on_out |=> porta_rfc_pad_out == 8'h00 && portb_rfc_pad_out == 6'h00)
    else $error("pad select active while disabled");
endmodule
bind mcr_top mcr_properties u_props (.clk_sys_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .slow_mode_in, .timer4_underflow_in, .ext_irq2_pin_in, .ext_irq1_pin_in, .edge_out,
  .timer1_reload_hi_out, .comparator_on_out, .res_freq_on_out, .porta_rfc_pad_out,
  .portb_rfc_pad_out, .rc_trim_value_out, .ext_irq2_flag_out, .timer_four_underflow_flag_out,
  .ext_irq2_enable_out, .ext_irq2_req_out, .ext_irq1_event_out);

/* test/testbench.sv */
// self-checking bench for the misc control register bank
// assumes mcr_top on a strobe bus; the checker is bound separately
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] TRIM = 8'hA5; // arbitrary factory trim
  localparam logic [7:0] PLAIN [5] = '{8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B};
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic slow_mode_in = 1'b0;
  logic [1:0] timer1_count_hi_in = 2'h0;
  logic [1:0] timer4_count_hi_in = 2'h0;
  logic timer4_underflow_in = 1'b0;
  logic ext_irq2_pin_in = 1'b0;
  logic ext_irq1_pin_in = 1'b0;
  logic ext_irq0_pin_in = 1'b0;
  logic [7:0] rdata_out;
  mcr_pkg::mcr_analog_t analog_out;
  mcr_pkg::mcr_offset_t offset_out;
  mcr_pkg::mcr_edge_t edge_out;
  mcr_pkg::mcr_duty_t duty_out;
  logic [1:0] timer1_reload_hi_out, timer4_reload_hi_out;
  logic comparator_on_out, res_freq_on_out;
  logic [3:0] res_freq_pad_out;
  logic [7:0] porta_rfc_pad_out;
  logic [5:0] portb_rfc_pad_out;
  logic [10:0] rc_trim_value_out;
  logic ext_irq2_flag_out, timer_four_underflow_flag_out, ext_irq2_enable_out, timer_four_underflow_enable_out;
  logic ext_irq2_req_out, timer_four_underflow_req_out, ext_irq1_event_out, ext_irq0_event_out;
  int fail_count = 0;
  int total_checks = 0;
  int ev1_count = 0;
  int ev0_count = 0;
  int ev1_base = 0;
  int ev0_base = 0;
  logic [31:0] seed = 32'hE12C;
  logic [7:0] r, d, a;
  logic [7:0] sh [32];
  logic [1:0] code;

  mcr_top #(.FACTORY_TRIM(TRIM)) uut (.clk_sys_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .slow_mode_in, .timer1_count_hi_in, .timer4_count_hi_in, .timer4_underflow_in,
    .ext_irq2_pin_in, .ext_irq1_pin_in, .ext_irq0_pin_in, .analog_out, .offset_out, .edge_out,
    .duty_out, .timer1_reload_hi_out, .timer4_reload_hi_out, .comparator_on_out, .res_freq_on_out,
    .res_freq_pad_out, .porta_rfc_pad_out, .portb_rfc_pad_out, .rc_trim_value_out, .ext_irq2_flag_out,
    .timer_four_underflow_flag_out, .ext_irq2_enable_out, .timer_four_underflow_enable_out,
    .ext_irq2_req_out, .timer_four_underflow_req_out, .ext_irq1_event_out, .ext_irq0_event_out);

  // 25 MHz clock
  initial forever #20 clk_sys_in = ~clk_sys_in;

  // event pulses are one cycle long, so count them on every edge
  always @(posedge clk_sys_in) begin
    if (ext_irq1_event_out === 1'b1) ev1_count <= ev1_count + 1;
    if (ext_irq0_event_out === 1'b1) ev0_count <= ev0_count + 1;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // readable bits of the plain registers; the rest read zero
  function automatic logic [7:0] mask(input logic [7:0] adr);
    case (adr)
      8'h17: return 8'h3F;
      8'h1A: return 8'h80;
      8'h1B: return 8'h8F;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // outputs land at the write edge, so look 1 ns later
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= adr;
    wdata_in <= dat;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= adr;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    check("read data", rdata_out, exp);
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    fail_count++;
    give_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    check("edge reset", edge_out, 8'h05);
    check("trim reset", rc_trim_value_out, {TRIM, 3'h0});
    check("cmp reset", comparator_on_out, 1'b0);
    rd(8'h1B, 8'h00);
    rd(8'h1F, 8'h00);
    // random traffic on the plain registers, shadowed for the output check
    for (int i = 0; i < 40; i++) begin
      a = PLAIN[i % 5];
      r = 8'(rnd());
      sh[a[4:0]] = r;
      wr(a, r);
      rd(a, r & mask(a));
    end
    check("analog", analog_out, sh[22]);
    check("offset", offset_out, sh[23][5:0]);
    check("edge", edge_out, sh[24]);
    check("cmp", comparator_on_out, sh[26][7]);
    check("rfc", {res_freq_on_out, res_freq_pad_out}, {sh[27][7], sh[27][3:0]});
    rd(8'h20, 8'h00);
    rd(8'h15, 8'h00);
    // timer high bytes: writes go to reload, reads show the counter
    for (int i = 0; i < 8; i++) begin
      r = 8'(rnd());
      d = 8'(rnd());
      a = 8'(rnd());
      @(posedge clk_sys_in);
      timer1_count_hi_in <= a[1:0];
      timer4_count_hi_in <= a[3:2];
      wr(8'h19, r);
      wr(8'h1C, d);
      check("t1 reload", timer1_reload_hi_out, r[5:4]);
      check("t4 reload", timer4_reload_hi_out, d[7:6]);
      check("duty", duty_out, {d[3:0], r[3:0]});
      rd(8'h19, {2'h0, a[1:0], r[3:0]});
      rd(8'h1C, {a[3:2], 2'h0, d[3:0]});
    end
    // every pad code, including the two that select nothing
    for (int c = 0; c < 16; c++) begin
      wr(8'h1B, 8'h80 | 8'(c));
      wait_cycles(1);
      check("pad a", porta_rfc_pad_out, (c < 8) ? 8'h01 << c : 8'h00);
      check("pad b", portb_rfc_pad_out, (c >= 8 && c < 14) ? 6'h01 << (c - 8) : 6'h00);
    end
    wr(8'h1B, 8'h03);
    wait_cycles(1);
    check("pad off", porta_rfc_pad_out, 8'h00);
    // trim is locked outside slow mode
    wr(8'h1E, 8'h5A);
    check("trim locked", rc_trim_value_out, {TRIM, 3'h0});
    @(posedge clk_sys_in);
    slow_mode_in <= 1'b1;
    wr(8'h1D, 8'hFF);
    wr(8'h1E, 8'h3C);
    check("trim", rc_trim_value_out, 11'h73C);
    rd(8'h1D, 8'h07);
    @(posedge clk_sys_in);
    slow_mode_in <= 1'b0;
    // underflow flag and request, then software clear
    wr(8'h1F, 8'h0C);
    @(posedge clk_sys_in);
    timer4_underflow_in <= 1'b1;
    @(posedge clk_sys_in);
    timer4_underflow_in <= 1'b0;
    wait_cycles(6);
    check("t4 flag req", {timer_four_underflow_flag_out, timer_four_underflow_req_out}, 2'h3);
    wr(8'h1F, 8'h0C);
    rd(8'h1F, 8'h0C);
    check("int2 enables", {ext_irq2_enable_out, timer_four_underflow_enable_out}, 2'h3);
    // irq2 on each edge polarity
    for (int e = 0; e < 2; e++) begin
      wr(8'h18, {e[0], 7'h45});
      @(posedge clk_sys_in);
      ext_irq2_pin_in <= 1'b1;
      wait_cycles(4);
      check("irq2 rise", ext_irq2_flag_out, e[0]);
      @(posedge clk_sys_in);
      ext_irq2_pin_in <= 1'b0;
      wait_cycles(4);
      check("irq2 flag", {ext_irq2_flag_out, ext_irq2_req_out}, 2'h3);
      wr(8'h1F, 8'h0C);
    end
    // every edge code on irq1 and irq0, then pins deselected
    for (int i = 0; i < 5; i++) begin
      code = (i == 4) ? 2'h3 : 2'(i);
      wr(8'h18, ((i < 4) ? 8'h30 : 8'h00) | {4'h0, code, code});
      ev1_base = ev1_count;
      ev0_base = ev0_count;
      @(posedge clk_sys_in);
      ext_irq1_pin_in <= 1'b1;
      ext_irq0_pin_in <= 1'b1;
      wait_cycles(4);
      @(posedge clk_sys_in);
      ext_irq1_pin_in <= 1'b0;
      ext_irq0_pin_in <= 1'b0;
      wait_cycles(4);
      d = (i == 0 || i == 4) ? 8'h00 : ((i == 3) ? 8'h02 : 8'h01);
      check("irq1 events", 11'(ev1_count - ev1_base), {3'h0, d});
      check("irq0 events", 11'(ev0_count - ev0_base), {3'h0, d});
    end
    give_verdict();
  end
endmodule
